// file: svcd_top.sv
// command decoder and executor for seek, write-and-check and check-only commands
// assumes a medium engine and two byte streams (reference and read-back) on clk_sys
// How it works
// RULE_01: opcode 2Bh is decoded as the seek command.
// RULE_02: seek asks the medium to position at the block address, zero blocks moved.
// RULE_03: opcode 2Eh is decoded as write-then-check.
// RULE_04: write-then-check writes all blocks first, then checks them.
// RULE_05: compare select clear means medium integrity check only, no byte compare.
// RULE_06: write-then-check with compare select set compares read-back against sent data.
// RULE_07: check-only with compare select compares reference stream against medium bytes.
// RULE_08: any byte mismatch ends with check condition and miscompare sense key.
// RULE_09: write-then-check starts at the command's four-byte block address.
// RULE_10: write-then-check length zero writes nothing and is not an error.
// RULE_11: opcode 2Fh is decoded as the check-only command.
// RULE_12: check-only starts at the command's four-byte block address.
// RULE_13: check-only length zero checks nothing and is not an error.
// RULE_14: opcodes 30h to 32h are handed to the separate search logic.
// RULE_15: fields sit at fixed bytes and bits, multibyte fields most significant first.
// RULE_16: seek ignores reserved bytes 6 to 8 and reserved bits of byte 1.
//
// Chosen here: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module svcd_top #(
  parameter int BLOCK_BYTES = 512,
  parameter logic [3:0] SENSE_MISCOMPARE = 4'hE,
  parameter logic [3:0] SENSE_MEDIUM_ERR = 4'h3,
  parameter logic [3:0] SENSE_ILLEGAL = 4'h5
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  output logic med_req,
  output svcd_pkg::svcd_mop_t med_op,
  output logic [31:0] med_lba,
  output logic [15:0] med_count,
  output logic [2:0] med_unit,
  output logic med_rel_addr,
  input wire logic med_ack,
  input wire logic med_fault,
  input wire logic ref_valid,
  input wire logic [7:0] ref_data,
  output logic ref_ready,
  input wire logic rd_valid,
  input wire logic [7:0] rd_data,
  output logic rd_ready,
  output logic search_start,
  output logic cmd_done
);
  import svcd_pkg::*;

  logic [31:0] cmd_w0, cmd_w1, cmd_w2;
  logic [IRQ_WIDTH-1:0] irq_stat, irq_mask, irq_set;
  logic bus_ack, go, status_check, then_chk, byte_cmp;
  logic [3:0] sense_key;
  logic [31:0] byte_cnt, byte_total;
  svcd_state_t state;
  logic [7:0] f_op, f_b1, f_b9;
  logic [31:0] f_lba;
  logic [15:0] f_len;
  logic xfer, mismatch;

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] d,
                                            input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction : be_merge

  // byte 0 sits in the top lane of word 0, so multibyte fields read straight across
  assign f_op = cmd_w0[31:24]; // RULE_15
  assign f_b1 = cmd_w0[23:16]; // RULE_15
  assign f_lba = {cmd_w0[15:0], cmd_w1[31:16]}; // RULE_15
  assign f_len = {cmd_w1[7:0], cmd_w2[15:8]}; // RULE_15
  assign f_b9 = cmd_w2[7:0]; // RULE_15

  // one wait cycle on every access keeps read data registered; writes land at the edge
  // that ends the wait, so a master that gives up early never half-writes a register
  assign avs_waitrequest = (avs_read | avs_write) & ~bus_ack;
  assign go = avs_write & bus_ack & (avs_address == REG_CTRL)
              & avs_byteenable[0] & avs_writedata[CTRL_GO_BIT];

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      bus_ack <= 1'b0;
    else
      bus_ack <= (avs_read | avs_write) & ~bus_ack;
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cmd_w0 <= CMD_RESET;
      cmd_w1 <= CMD_RESET;
      cmd_w2 <= CMD_RESET;
      irq_mask <= IRQ_RESET;
    end
    else if (avs_write && bus_ack)
    begin
      case (avs_address)
        REG_CMD_W0: cmd_w0 <= be_merge(cmd_w0, avs_writedata, avs_byteenable);
        REG_CMD_W1: cmd_w1 <= be_merge(cmd_w1, avs_writedata, avs_byteenable);
        REG_CMD_W2: cmd_w2 <= be_merge(cmd_w2, avs_writedata, avs_byteenable)
                              & 32'h0000_FFFF;
        REG_IRQ_MASK: irq_mask <= avs_writedata[IRQ_WIDTH-1:0];
        default: ;
      endcase
    end
  end

  // set wins over a write-one clear landing in the same cycle
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      irq_stat <= IRQ_RESET;
    else if (avs_write && bus_ack && avs_address == REG_IRQ_STAT && avs_byteenable[0])
      irq_stat <= (irq_stat & ~avs_writedata[IRQ_WIDTH-1:0]) | irq_set;
    else
      irq_stat <= irq_stat | irq_set;
  end
  assign irq = |(irq_stat & irq_mask);

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      avs_readdata <= 32'h0000_0000;
    else if (avs_read && !bus_ack)
    begin
      case (avs_address)
        REG_CMD_W0: avs_readdata <= cmd_w0;
        REG_CMD_W1: avs_readdata <= cmd_w1;
        REG_CMD_W2: avs_readdata <= cmd_w2;
        REG_STATUS: avs_readdata <= {24'h000000, sense_key, 2'h0, status_check,
                                     state != S_IDLE};
        REG_IRQ_STAT: avs_readdata <= {29'h0000_0000, irq_stat};
        REG_IRQ_MASK: avs_readdata <= {29'h0000_0000, irq_mask};
        default: avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // both streams advance together, one byte pair per cycle
  assign xfer = (state == S_CMP) & ref_valid & rd_valid; // RULE_07
  assign ref_ready = xfer; // RULE_06
  assign rd_ready = xfer;
  assign mismatch = ref_data != rd_data;
  assign irq_set = {search_start, xfer & mismatch, cmd_done};

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state <= S_IDLE;
      med_req <= 1'b0;
      med_op <= MOP_SEEK;
      med_lba <= 32'h0000_0000;
      med_count <= 16'h0000;
      med_unit <= 3'h0;
      med_rel_addr <= 1'b0;
      then_chk <= 1'b0;
      byte_cmp <= 1'b0;
      status_check <= 1'b0;
      sense_key <= SENSE_RESET;
      byte_cnt <= 32'h0000_0000;
      byte_total <= 32'h0000_0000;
      search_start <= 1'b0;
      cmd_done <= 1'b0;
    end
    else
    begin
      search_start <= 1'b0;
      cmd_done <= 1'b0;
      case (state)
        S_IDLE:
        begin
          if (go)
            state <= S_DEC;
        end
        S_DEC:
        begin
          status_check <= 1'b0;
          sense_key <= SENSE_RESET;
          then_chk <= 1'b0;
          med_lba <= f_lba; // RULE_09 RULE_12
          med_count <= f_len;
          med_unit <= f_b1[7:5];
          med_rel_addr <= f_b1[B1_RELATIVE_ADDRESS_SELECT_BIT];
          byte_cmp <= f_b1[B1_BYTCMP_BIT];
          byte_total <= 32'(f_len) * 32'(BLOCK_BYTES);
          if (f_op == OPC_SEEK) // RULE_01
          begin
            // only the address and the unit bits 7:5 of byte 1 count; bytes 6-8 and byte 1 flags are not looked at
            med_op <= MOP_SEEK; // RULE_02 RULE_16
            med_count <= 16'h0000; // RULE_02
            med_rel_addr <= 1'b0; // RULE_16
            state <= S_MED;
          end
          else if (f_op == OPC_WRCHK || f_op == OPC_CHK) // RULE_03 RULE_11
          begin
            if (f_len == 16'h0000)
              state <= S_FIN; // RULE_10 RULE_13
            else
            begin
              then_chk <= f_op == OPC_WRCHK; // RULE_04
              if (f_op == OPC_WRCHK)
                med_op <= MOP_WRITE; // RULE_04
              else
                med_op <= f_b1[B1_BYTCMP_BIT] ? MOP_READ : MOP_CHECK; // RULE_05 RULE_07
              state <= S_MED;
            end
          end
          else if (f_op >= OPC_SRCH_LO && f_op <= OPC_SRCH_HI)
          begin
            search_start <= 1'b1; // RULE_14
            state <= S_FIN;
          end
          else
          begin
            status_check <= 1'b1;
            sense_key <= SENSE_ILLEGAL;
            state <= S_FIN;
          end
        end
        S_MED:
        begin
          // request is dropped for a cycle between phases so each is a fresh handshake
          if (!med_req)
            med_req <= 1'b1;
          else if (med_ack)
          begin
            med_req <= 1'b0;
            if (med_fault)
            begin
              status_check <= 1'b1;
              sense_key <= SENSE_MEDIUM_ERR;
              state <= S_FIN;
            end
            else if (then_chk)
            begin
              then_chk <= 1'b0;
              med_op <= byte_cmp ? MOP_READ : MOP_CHECK; // RULE_04 RULE_05 RULE_06
            end
            else if (med_op == MOP_READ)
            begin
              byte_cnt <= 32'h0000_0000;
              state <= S_CMP;
            end
            else
              state <= S_FIN;
          end
        end
        S_CMP:
        begin
          if (xfer)
          begin
            byte_cnt <= byte_cnt + 32'h0000_0001;
            if (mismatch)
            begin
              status_check <= 1'b1; // RULE_08
              sense_key <= SENSE_MISCOMPARE; // RULE_08
              state <= S_FIN;
            end
            else if (byte_cnt == byte_total - 32'h0000_0001)
              state <= S_FIN;
          end
        end
        S_FIN:
        begin
          cmd_done <= 1'b1;
          state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  a_seek_nodata: assert property (@(posedge clk_sys) disable iff (!rst_b) // RULE_02
    (med_req && med_op == MOP_SEEK) |-> (med_count == 16'h0000 && !ref_ready))
    else $error("seek moves data");
  a_miscmp_key: assert property (@(posedge clk_sys) disable iff (!rst_b) // RULE_08
    (xfer && mismatch) |=> (status_check && sense_key == SENSE_MISCOMPARE) ##1 cmd_done)
    else $error("miscompare not reported");
  a_zero_wrchk: assert property (@(posedge clk_sys) disable iff (!rst_b) // RULE_10
    (state == S_DEC && f_op == OPC_WRCHK && f_len == 16'h0000)
    |=> (state == S_FIN && !status_check && !med_req) ##1 cmd_done)
    else $error("zero length write-check misbehaves");
  a_zero_chk: assert property (@(posedge clk_sys) disable iff (!rst_b) // RULE_13
    (state == S_DEC && f_op == OPC_CHK && f_len == 16'h0000)
    |=> !med_req [*2] ##0 !status_check)
    else $error("zero length check misbehaves");
  a_search_hand: assert property (@(posedge clk_sys) disable iff (!rst_b) // RULE_14
    (state == S_DEC && f_op >= OPC_SRCH_LO && f_op <= OPC_SRCH_HI)
    |=> search_start && !med_req)
    else $error("search not handed off");
  a_write_lba: assert property (@(posedge clk_sys) disable iff (!rst_b) // RULE_09
    (state == S_DEC && f_op == OPC_WRCHK && f_len != 16'h0000)
    |=> (med_op == MOP_WRITE && med_lba == $past(f_lba)))
    else $error("write start address wrong");
  a_chk_lba: assert property (@(posedge clk_sys) disable iff (!rst_b) // RULE_12
    (state == S_DEC && f_op == OPC_CHK && f_len != 16'h0000)
    |=> (med_op != MOP_WRITE && med_lba == $past(f_lba)))
    else $error("check start address wrong");
  a_write_first: assert property (@(posedge clk_sys) disable iff (!rst_b) // RULE_04
    (med_req && med_ack && med_op == MOP_WRITE && !med_fault)
    |=> (!med_req && med_op != MOP_WRITE) ##1 med_req)
    else $error("check phase does not follow write");
  a_plain_chk: assert property (@(posedge clk_sys) disable iff (!rst_b) // RULE_05
    (med_req && med_op == MOP_CHECK) |-> (!ref_ready && !rd_ready))
    else $error("byte compare during integrity check");
  a_ready_cmp: assert property (@(posedge clk_sys) disable iff (!rst_b) // RULE_07
    ref_ready |-> (state == S_CMP && byte_cmp && rd_ready))
    else $error("reference consumed outside compare");
  a_opc_seek: assert property (@(posedge clk_sys) disable iff (!rst_b) // RULE_01
    (state == S_DEC && f_op == OPC_SEEK) |=> (state == S_MED && med_op == MOP_SEEK))
    else $error("seek opcode not decoded");
endmodule : svcd_top
`default_nettype wire

// file: svcd_pkg.sv
// constants for the seek / write-and-check / check-only command decoder
// assumes a ten-byte command block loaded by software over the register bus
package svcd_pkg;
  // opcodes
  localparam logic [7:0] OPC_SEEK = 8'h2B;
  localparam logic [7:0] OPC_WRCHK = 8'h2E;
  localparam logic [7:0] OPC_CHK = 8'h2F;
  localparam logic [7:0] OPC_SRCH_LO = 8'h30;
  localparam logic [7:0] OPC_SRCH_HI = 8'h32;
  // byte offsets of the register map
  localparam logic [4:0] REG_CMD_W0 = 5'h00;
  localparam logic [4:0] REG_CMD_W1 = 5'h04;
  localparam logic [4:0] REG_CMD_W2 = 5'h08;
  localparam logic [4:0] REG_CTRL = 5'h0C;
  localparam logic [4:0] REG_STATUS = 5'h10;
  localparam logic [4:0] REG_IRQ_STAT = 5'h14;
  localparam logic [4:0] REG_IRQ_MASK = 5'h18;
  // field positions
  localparam int CTRL_GO_BIT = 0;
  localparam int B1_BYTCMP_BIT = 1;
  localparam int B1_RELATIVE_ADDRESS_SELECT_BIT = 0;
  localparam int B9_FLAG_BIT = 1;
  localparam int B9_LINK_BIT = 0;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_MISCMP_BIT = 1;
  localparam int IRQ_SEARCH_BIT = 2;
  localparam int IRQ_WIDTH = 3;
  // reset values
  localparam logic [31:0] CMD_RESET = 32'h0000_0000;
  localparam logic [IRQ_WIDTH-1:0] IRQ_RESET = 3'h0;
  localparam logic [3:0] SENSE_RESET = 4'h0;
  // medium operations
  typedef enum logic [1:0] {
    MOP_SEEK = 2'h0,
    MOP_WRITE = 2'h1,
    MOP_CHECK = 2'h2,
    MOP_READ = 2'h3
  } svcd_mop_t;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_DEC = 3'b001,
    S_MED = 3'b011,
    S_CMP = 3'b010,
    S_FIN = 3'b110
  } svcd_state_t;
endpackage : svcd_pkg

// file: svcd_med_model.sv
// medium engine and byte-stream model standing behind the command decoder
// assumes clk_sys and rst_b of the decoder; the bench sets fault and the bad byte index
`timescale 1ns/1ns
`default_nettype none
module svcd_med_model (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic med_req,
  input wire logic rd_ready,
  input wire logic fault_en,
  input wire logic [15:0] bad_idx,
  output logic med_ack,
  output logic med_fault,
  output logic ref_valid,
  output logic rd_valid,
  output logic [7:0] ref_data,
  output logic [7:0] rd_data
);
  logic [1:0] wait_cnt;
  logic [15:0] idx;
  logic [7:0] pat;
  assign pat = idx[7:0] ^ 8'h5A;
  // idle lines carry the inverted byte so a stale value never passes for data
  assign rd_data = rd_valid ? pat : ~pat;
  assign ref_data = (ref_valid && idx != bad_idx) ? pat : ~pat;
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      med_ack <= 1'b0;
      med_fault <= 1'b0;
      wait_cnt <= 2'h2;
    end
    else
    begin
      med_ack <= 1'b0;
      med_fault <= 1'b0;
      if (med_req && !med_ack && wait_cnt != 2'h0)
        wait_cnt <= wait_cnt - 2'h1;
      else if (med_req && !med_ack)
      begin
        med_ack <= 1'b1;
        med_fault <= fault_en;
        wait_cnt <= 2'($urandom_range(0, 3));
      end
    end
  end
  // both streams stall at random, a raised valid holds until the pair is taken,
  // and the reference restarts with every medium answer
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rd_valid <= 1'b0;
      ref_valid <= 1'b0;
      idx <= 16'h0;
    end
    else
    begin
      if (!rd_valid || rd_ready)
        rd_valid <= ($urandom_range(0, 3) != 0);
      if (!ref_valid || rd_ready)
        ref_valid <= ($urandom_range(0, 3) != 0);
      if (med_ack)
        idx <= 16'h0;
      else if (rd_ready)
        idx <= idx + 16'h1;
    end
  end
endmodule : svcd_med_model
`default_nettype wire

// file: tb_seek_verify_cmd_decoder.sv
// self-checking bench: commands loaded and started over the register bus
// assumes svcd_pkg, svcd_top and svcd_med_model are compiled before it
`timescale 1ns/1ns
`default_nettype none
module tb_seek_verify_cmd_decoder;
  import svcd_pkg::*;
  localparam int BB = 4;
  // the last entry is an opcode this block does not serve
  localparam logic [7:0] OPCS [14] = '{8'h2B, 8'h2E, 8'h2E, 8'h2E, 8'h2F, 8'h2F, 8'h2F,
    8'h2E, 8'h2F, 8'h30, 8'h31, 8'h32, 8'h2F, 8'h2C};
  localparam logic [7:0] B1S [14] = '{8'hBF, 8'h20, 8'h43, 8'h02, 8'h61, 8'h82, 8'h02,
    8'h02, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [15:0] LENS [14] = '{16'h1234, 16'h2, 16'h1, 16'h1, 16'h3, 16'h2, 16'h2,
    16'h0, 16'h0, 16'h1, 16'h1, 16'h1, 16'h1, 16'h1};
  // FFFE marks a medium fault instead of a bad byte
  localparam logic [15:0] BADS [14] = '{16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h2, 16'hFFFF,
    16'hFFFF, 16'h7, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFE, 16'hFFFF};
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic fault_en = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [15:0] bad_idx = 16'hFFFF;
  logic [31:0] avs_readdata, med_lba;
  logic avs_waitrequest, irq, med_req, med_ack, med_fault, ref_valid, rd_valid, ref_ready;
  logic rd_ready, search_start, cmd_done, med_rel_addr;
  svcd_mop_t med_op;
  logic [15:0] med_count;
  logic [2:0] med_unit;
  logic [7:0] ref_data, rd_data;
  logic [63:0] note_q[$];
  int mismatches = 0;
  int comparisons = 0;
  int srch_n = 0;
  svcd_top #(.BLOCK_BYTES(BB)) DUT (.clk_sys, .rst_b, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .irq, .med_req,
    .med_op, .med_lba, .med_count, .med_unit, .med_rel_addr, .med_ack, .med_fault, .ref_valid,
    .ref_data, .ref_ready, .rd_valid, .rd_data, .rd_ready, .search_start, .cmd_done);
  svcd_med_model u_med (.clk_sys, .rst_b, .med_req, .rd_ready, .fault_en, .bad_idx, .med_ack,
    .med_fault, .ref_valid, .rd_valid, .ref_data, .rd_data);
  initial
  begin
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error at %0t: seen %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic close_out();
    $display("mismatches %0d, comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : close_out
  // one access; waitrequest and read data are taken at the rising edge that ends the wait
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0)
    begin
      mismatches++;
      close_out();
    end
    else
    begin
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
    end
  endtask : bus
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, q);
  endtask : rd
  always @(posedge clk_sys)
  begin
    if (search_start === 1'b1)
      srch_n++;
    if (med_req === 1'b1 && med_ack === 1'b1 && note_q.size() == 0)
      check(64'h1, 64'h0);
    else if (med_req === 1'b1 && med_ack === 1'b1)
      check({10'h0, med_op, med_lba, med_count, med_unit, med_rel_addr},
            note_q.pop_front());
  end
  task automatic run(input logic [7:0] opc, input logic [7:0] b1, input logic [15:0] len,
                     input logic [15:0] bad);
    logic [31:0] lba, q;
    logic mis, flt, srch, ill;
    int s0;
    lba = $urandom;
    mis = bad < len * BB;
    flt = (bad == 16'hFFFE);
    srch = (opc >= OPC_SRCH_LO && opc <= OPC_SRCH_HI);
    ill = !(opc == OPC_SEEK || opc == OPC_WRCHK || opc == OPC_CHK || srch);
    s0 = srch_n;
    bad_idx <= bad;
    fault_en <= flt;
    if (opc == OPC_SEEK)
      note_q.push_back({10'h0, MOP_SEEK, lba, 16'h0, b1[7:5], 1'b0});
    if (opc == OPC_WRCHK && len != 0)
      note_q.push_back({10'h0, MOP_WRITE, lba, len, b1[7:5], b1[0]});
    if ((opc == OPC_WRCHK || opc == OPC_CHK) && len != 0)
      note_q.push_back({10'h0, b1[1] ? MOP_READ : MOP_CHECK, lba, len, b1[7:5], b1[0]});
    wr(REG_CMD_W0, {opc, b1, lba[31:16]});
    wr(REG_CMD_W1, {lba[15:0], 8'hA5, len[15:8]});
    wr(REG_CMD_W2, {16'h0, len[7:0], 8'h03});
    wr(REG_CTRL, 32'h1);
    wait_done();
    @(negedge clk_sys);
    check(irq, 1'b1); // done event with the mask open
    wr(REG_IRQ_MASK, 32'h0);
    @(negedge clk_sys);
    check(irq, 1'b0); // masked
    wr(REG_IRQ_MASK, 32'h7);
    check(note_q.size(), 0);
    rd(REG_STATUS, q);
    check(q, {24'h0, mis ? 4'hE : flt ? 4'h3 : ill ? 4'h5 : 4'h0, 2'b0,
              mis | flt | ill, 1'b0});
    rd(REG_IRQ_STAT, q);
    check(q, {29'h0, srch, mis, 1'b1});
    check(srch_n - s0, srch);
    wr(REG_IRQ_STAT, 32'h7);
    @(negedge clk_sys);
    check(irq, 1'b0); // cleared by writing ones
  endtask : run
  task automatic wait_done();
    int n;
    n = 0;
    do
    begin
      @(negedge clk_sys);
      n++;
    end
    while (cmd_done !== 1'b1 && n < 3000);
    if (cmd_done !== 1'b1)
    begin
      mismatches++;
      close_out();
    end
  endtask : wait_done
  initial
  begin
    logic [31:0] q;
    void'($urandom(32'h8560));
    repeat (12) @(posedge clk_sys);
    rst_b <= 1'b1;
    rd(REG_IRQ_STAT, q);
    check(q, {29'h0, IRQ_RESET});
    rd(5'h1C, q);
    check(q, 32'h0);
    wr(REG_IRQ_MASK, 32'h7);
    for (int i = 0; i < 14; i++)
      run(OPCS[i], B1S[i], LENS[i], BADS[i]);
    close_out();
  end
endmodule : tb_seek_verify_cmd_decoder
`default_nettype wire
